// *** rtl/fbo_map.svh ***
// Register offsets, field positions, reset values and cycle counts
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers
// Overview of operation
// RULE_01: Taken branch loads PC plus offset plus one; no flags; 1 or 2 cycles.
// RULE_02: Equal branch when zero flag set, not-equal branch when it is clear.
// RULE_03: Carry-set and lower branch on carry 1; carry-clear and same-or-higher on 0.
// RULE_04: Minus branch when negative flag 1, plus branch when it is 0.
// RULE_05: Signed ge branch when N xor V is 0; signed lt when it is 1.
// RULE_06: Two half-carry branches, one on set and one on clear.
// RULE_07: Two transfer-flag branches, one on set and one on clear.
// RULE_08: Interrupts-enabled branch adds offset plus one when I is 1.
// RULE_09: Interrupts-disabled branch adds offset plus one when I is 0.
// RULE_10: I/O bit set and clear force one bit, two cycles, flags untouched.
// RULE_11: Rotate left through carry: old carry to bit 0, bit 7 to carry.
// RULE_12: Rotate right through carry: old carry to bit 7, bit 0 to carry.
// RULE_13: Bit store copies a register bit into T, no other flag changes.
// RULE_14: Bit load copies T into a register bit, flags unchanged.
// RULE_15: Logical shifts fill with 0, arithmetic right keeps bit 7; update ZCNV.
// RULE_16: Nibble swap exchanges low and high nibble, one cycle, no flags.
// RULE_17: Flag set and clear forms write only the selected flag, one cycle.
`ifndef FBO_MAP_SVH
`define FBO_MAP_SVH

`define FBO_OFF_INSTR 8'h00
`define FBO_OFF_STATUS_REGISTER 8'h04
`define FBO_OFF_PC 8'h08
`define FBO_OFF_GPR 8'h0c
`define FBO_OFF_IO 8'h10
`define FBO_OFF_STAT 8'h14

`define FBO_INS_OP_LO 0
`define FBO_INS_OP_HI 5
`define FBO_INS_BIT_LO 8
`define FBO_INS_BIT_HI 10
`define FBO_INS_K_LO 16
`define FBO_INS_K_HI 22

`define FBO_STATUS_REGISTER_C 0
`define FBO_STATUS_REGISTER_Z 1
`define FBO_STATUS_REGISTER_N 2
`define FBO_STATUS_REGISTER_V 3
`define FBO_STATUS_REGISTER_S 4
`define FBO_STATUS_REGISTER_H 5
`define FBO_STATUS_REGISTER_T 6
`define FBO_STATUS_REGISTER_I 7

`define FBO_RST_STATUS_REGISTER 8'h00
`define FBO_RST_GPR 8'h00
`define FBO_RST_IO 8'h00
`define FBO_RST_INSTR 32'h0000_0000

`define FBO_CYC_ONE 2'h1
`define FBO_CYC_TWO 2'h2

`define FBO_RESP_OKAY 2'h0
`define FBO_RESP_SLVERR 2'h2

`endif

// *** rtl/fbo_pkg.sv ***
// Types and shared decoding for the flag, branch and bit unit
// Assumes the map header supplies all numeric constants
`include "fbo_map.svh"

package fbo_pkg;

    typedef enum logic [5:0] {
        op_nop,
        op_branch_equal,
        op_branch_not_equal,
        op_branch_carry_set,
        op_branch_carry_clear,
        op_branch_same_or_higher,
        op_branch_lower,
        op_branch_minus,
        op_branch_plus,
        op_branch_signed_ge,
        op_branch_signed_lt,
        op_branch_halfcarry_set,
        op_branch_halfcarry_clear,
        op_branch_tflag_set,
        op_branch_tflag_clear,
        op_branch_irq_enabled,
        op_branch_irq_disabled,
        op_io_bit_set,
        op_io_bit_clear,
        op_shift_left_logical,
        op_shift_right_logical,
        op_rotate_left_carry,
        op_rotate_right_carry,
        op_shift_right_arith,
        op_nibble_swap,
        op_flag_set_generic,
        op_flag_clear_generic,
        op_bit_to_transfer_flag,
        op_transfer_flag_to_bit,
        op_carry_set_op,
        op_carry_clear_op,
        op_negative_set_op,
        op_negative_clear_op
    } fbo_op_t;

    function automatic logic fbo_is_branch(input fbo_op_t op);
        fbo_is_branch = (op >= op_branch_equal) &&
            (op <= op_branch_irq_disabled);
    endfunction : fbo_is_branch

    function automatic logic fbo_branch_taken(input fbo_op_t op,
        input logic [7:0] s);
        logic sv;
        sv = s[`FBO_STATUS_REGISTER_N] ^ s[`FBO_STATUS_REGISTER_V];
        case (op)
            op_branch_equal: fbo_branch_taken = s[`FBO_STATUS_REGISTER_Z]; // RULE_02
            op_branch_not_equal: fbo_branch_taken = !s[`FBO_STATUS_REGISTER_Z];
            op_branch_carry_set,
            op_branch_lower: fbo_branch_taken = s[`FBO_STATUS_REGISTER_C]; // RULE_03
            op_branch_carry_clear,
            op_branch_same_or_higher: fbo_branch_taken = !s[`FBO_STATUS_REGISTER_C];
            op_branch_minus: fbo_branch_taken = s[`FBO_STATUS_REGISTER_N]; // RULE_04
            op_branch_plus: fbo_branch_taken = !s[`FBO_STATUS_REGISTER_N];
            op_branch_signed_ge: fbo_branch_taken = !sv; // RULE_05
            op_branch_signed_lt: fbo_branch_taken = sv;
            op_branch_halfcarry_set:
                fbo_branch_taken = s[`FBO_STATUS_REGISTER_H]; // RULE_06
            op_branch_halfcarry_clear: fbo_branch_taken = !s[`FBO_STATUS_REGISTER_H];
            op_branch_tflag_set: fbo_branch_taken = s[`FBO_STATUS_REGISTER_T]; // RULE_07
            op_branch_tflag_clear: fbo_branch_taken = !s[`FBO_STATUS_REGISTER_T];
            op_branch_irq_enabled:
                fbo_branch_taken = s[`FBO_STATUS_REGISTER_I]; // RULE_08
            op_branch_irq_disabled:
                fbo_branch_taken = !s[`FBO_STATUS_REGISTER_I]; // RULE_09
            default: fbo_branch_taken = 1'b0;
        endcase
    endfunction : fbo_branch_taken

endpackage : fbo_pkg

// *** rtl/fbo_exec_if.sv ***
// Operand and result bundle between the register shell and the executor
// Assumes the shell drives operands and the executor answers in one cycle
`timescale 1ns/1ps

interface fbo_exec_if #(
    parameter int PC_W = 16
);
    fbo_pkg::fbo_op_t op;
    logic [7:0] status_register;
    logic [PC_W-1:0] pc;
    logic [7:0] gpr;
    logic [7:0] io;
    logic [2:0] bsel;
    logic [6:0] k;
    logic [7:0] status_register_n;
    logic [PC_W-1:0] pc_n;
    logic [7:0] gpr_n;
    logic [7:0] io_n;
    logic [1:0] cycles;
    logic taken;

    modport core (
        output op, status_register, pc, gpr, io, bsel, k,
        input status_register_n, pc_n, gpr_n, io_n, cycles, taken
    );
    modport unit (
        input op, status_register, pc, gpr, io, bsel, k,
        output status_register_n, pc_n, gpr_n, io_n, cycles, taken
    );
endinterface : fbo_exec_if

// *** rtl/fbo_exec.sv ***
// Combinational executor for branches, shifts and single-bit operations
// Assumes operands are stable for the cycle in which results are taken
`timescale 1ns/1ps
`include "fbo_map.svh"

module fbo_exec (
    fbo_exec_if.unit x
);
    localparam int PC_W = $bits(x.pc);

    logic [7:0] g;
    logic [7:0] r;
    logic [7:0] f;
    logic [7:0] o;
    logic c;
    logic shf;
    logic tk;

    always_comb
    begin
        g = x.gpr;
        r = g;
        f = x.status_register;
        o = x.io;
        c = x.status_register[`FBO_STATUS_REGISTER_C];
        shf = 1'b0;
        tk = fbo_pkg::fbo_branch_taken(x.op, x.status_register);
        x.cycles = `FBO_CYC_ONE;
        x.pc_n = x.pc + PC_W'(1);
        case (x.op)
            fbo_pkg::op_io_bit_set:
            begin
                o[x.bsel] = 1'b1; // RULE_10
                x.cycles = `FBO_CYC_TWO;
            end
            fbo_pkg::op_io_bit_clear:
            begin
                o[x.bsel] = 1'b0; // RULE_10
                x.cycles = `FBO_CYC_TWO;
            end
            fbo_pkg::op_shift_left_logical:
            begin
                r = {g[6:0], 1'b0}; // RULE_15
                c = g[7];
                shf = 1'b1;
            end
            fbo_pkg::op_shift_right_logical:
            begin
                r = {1'b0, g[7:1]}; // RULE_15
                c = g[0];
                shf = 1'b1;
            end
            fbo_pkg::op_rotate_left_carry:
            begin
                r = {g[6:0], x.status_register[`FBO_STATUS_REGISTER_C]}; // RULE_11
                c = g[7];
                shf = 1'b1;
            end
            fbo_pkg::op_rotate_right_carry:
            begin
                r = {x.status_register[`FBO_STATUS_REGISTER_C], g[7:1]}; // RULE_12
                c = g[0];
                shf = 1'b1;
            end
            fbo_pkg::op_shift_right_arith:
            begin
                r = {g[7], g[7:1]}; // RULE_15
                c = g[0];
                shf = 1'b1;
            end
            fbo_pkg::op_nibble_swap: r = {g[3:0], g[7:4]}; // RULE_16
            fbo_pkg::op_flag_set_generic: f[x.bsel] = 1'b1; // RULE_17
            fbo_pkg::op_flag_clear_generic: f[x.bsel] = 1'b0; // RULE_17
            fbo_pkg::op_bit_to_transfer_flag:
                f[`FBO_STATUS_REGISTER_T] = g[x.bsel]; // RULE_13
            fbo_pkg::op_transfer_flag_to_bit:
                r[x.bsel] = x.status_register[`FBO_STATUS_REGISTER_T]; // RULE_14
            fbo_pkg::op_carry_set_op: f[`FBO_STATUS_REGISTER_C] = 1'b1; // RULE_17
            fbo_pkg::op_carry_clear_op: f[`FBO_STATUS_REGISTER_C] = 1'b0; // RULE_17
            fbo_pkg::op_negative_set_op: f[`FBO_STATUS_REGISTER_N] = 1'b1; // RULE_17
            fbo_pkg::op_negative_clear_op: f[`FBO_STATUS_REGISTER_N] = 1'b0; // RULE_17
            default:
            begin
                if (fbo_pkg::fbo_is_branch(x.op) && tk)
                begin
                    x.pc_n = x.pc + PC_W'($signed(x.k)) + PC_W'(1); // RULE_01
                    x.cycles = `FBO_CYC_TWO; // RULE_01
                end
            end
        endcase
        if (shf)
        begin
            f[`FBO_STATUS_REGISTER_C] = c; // RULE_15
            f[`FBO_STATUS_REGISTER_Z] = (r == 8'h00);
            f[`FBO_STATUS_REGISTER_N] = r[7];
            f[`FBO_STATUS_REGISTER_V] = r[7] ^ c;
        end
        x.status_register_n = f;
        x.gpr_n = r;
        x.io_n = o;
        x.taken = fbo_pkg::fbo_is_branch(x.op) && tk;
    end
endmodule : fbo_exec

// *** rtl/fbo_top.sv ***
// AXI4-Lite register shell that issues one instruction per INSTR write
// Assumes a single AXI4-Lite master on aclk; only address bits 7:0 are decoded, and unmapped offsets get SLVERR
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fbo_map.svh"

module fbo_top #(
    parameter int PC_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic busy
);
    generate
        if (PC_W < 8 || PC_W > 32)
        begin : g_bad_pc
            $error("fbo_top: PC_W must lie in 8..32");
        end
        if (ADDR_W < 8 || ADDR_W > 32)
        begin : g_bad_addr
            $error("fbo_top: ADDR_W must lie in 8..32");
        end
    endgenerate

    typedef struct packed {
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [31:0] r_d;
        logic [1:0] r_r;
        logic [31:0] instr;
        logic [7:0] status_register;
        logic [PC_W-1:0] pc;
        logic [7:0] gpr;
        logic [7:0] io;
        logic busy;
        logic start;
        logic cnt;
        logic taken;
        logic [1:0] cycles;
    } fbo_state_t;

    fbo_state_t q;
    fbo_state_t d;
    logic wr_go;

    fbo_exec_if #(.PC_W(PC_W)) x ();

    fbo_exec u_exec (
        .x(x)
    );

    assign x.op = fbo_pkg::fbo_op_t'(q.instr[`FBO_INS_OP_HI:`FBO_INS_OP_LO]);
    assign x.status_register = q.status_register;
    assign x.pc = q.pc;
    assign x.gpr = q.gpr;
    assign x.io = q.io;
    assign x.bsel = q.instr[`FBO_INS_BIT_HI:`FBO_INS_BIT_LO];
    assign x.k = q.instr[`FBO_INS_K_HI:`FBO_INS_K_LO];

    function automatic logic [31:0] fbo_merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        fbo_merge = m;
    endfunction : fbo_merge

    function automatic logic fbo_mapped(input logic [7:0] a);
        fbo_mapped = (a == `FBO_OFF_INSTR) || (a == `FBO_OFF_STATUS_REGISTER) ||
            (a == `FBO_OFF_PC) || (a == `FBO_OFF_GPR) ||
            (a == `FBO_OFF_IO) || (a == `FBO_OFF_STAT);
    endfunction : fbo_mapped

    function automatic logic [31:0] fbo_read(input fbo_state_t s,
        input logic [7:0] a);
        case (a)
            `FBO_OFF_INSTR: fbo_read = s.instr;
            `FBO_OFF_STATUS_REGISTER: fbo_read = {24'h000000, s.status_register};
            `FBO_OFF_PC: fbo_read = 32'(s.pc);
            `FBO_OFF_GPR: fbo_read = {24'h000000, s.gpr};
            `FBO_OFF_IO: fbo_read = {24'h000000, s.io};
            `FBO_OFF_STAT:
                fbo_read = {28'h0000000, s.cycles, s.taken, s.busy};
            default: fbo_read = 32'h0000_0000;
        endcase
    endfunction : fbo_read

    assign s_axi_awready = !q.aw_v;
    assign s_axi_wready = !q.w_v;
    assign s_axi_arready = !q.r_v;
    assign s_axi_bvalid = q.b_v;
    assign s_axi_bresp = q.b_r;
    assign s_axi_rvalid = q.r_v;
    assign s_axi_rdata = q.r_d;
    assign s_axi_rresp = q.r_r;
    assign busy = q.busy;
    // Writes wait while an instruction is still running
    assign wr_go = q.aw_v && q.w_v && !q.b_v && !q.busy;

    always_comb
    begin
        logic [31:0] wv;
        wv = 32'h0000_0000;
        d = q;
        d.start = 1'b0;
        if (s_axi_awvalid && !q.aw_v)
        begin
            d.aw_v = 1'b1;
            d.aw_a = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !q.w_v)
        begin
            d.w_v = 1'b1;
            d.w_d = s_axi_wdata;
            d.w_s = s_axi_wstrb;
        end
        if (q.b_v && s_axi_bready)
        begin
            d.b_v = 1'b0;
        end
        if (q.r_v && s_axi_rready)
        begin
            d.r_v = 1'b0;
        end
        if (s_axi_arvalid && !q.r_v)
        begin
            d.r_v = 1'b1;
            d.r_d = fbo_read(q, s_axi_araddr[7:0]);
            d.r_r = fbo_mapped(s_axi_araddr[7:0]) ? `FBO_RESP_OKAY :
                `FBO_RESP_SLVERR;
        end
        // Execute: commit results, hold busy for the second cycle
        if (q.start)
        begin
            d.status_register = x.status_register_n;
            d.pc = x.pc_n; // RULE_01
            d.gpr = x.gpr_n;
            d.io = x.io_n;
            d.taken = x.taken;
            d.cycles = x.cycles;
            d.cnt = (x.cycles == `FBO_CYC_TWO); // RULE_01 RULE_10
            d.busy = (x.cycles == `FBO_CYC_TWO);
        end
        else if (q.busy && q.cnt)
        begin
            d.cnt = 1'b0;
            d.busy = 1'b0;
        end
        if (wr_go)
        begin
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.b_v = 1'b1;
            d.b_r = fbo_mapped(q.aw_a) ? `FBO_RESP_OKAY : `FBO_RESP_SLVERR;
            case (q.aw_a)
                `FBO_OFF_INSTR:
                begin
                    d.instr = fbo_merge(q.instr, q.w_d, q.w_s);
                    d.busy = 1'b1;
                    d.start = 1'b1;
                end
                `FBO_OFF_STATUS_REGISTER:
                begin
                    wv = fbo_merge({24'h000000, q.status_register}, q.w_d, q.w_s);
                    d.status_register = wv[7:0];
                end
                `FBO_OFF_PC:
                begin
                    wv = fbo_merge(32'(q.pc), q.w_d, q.w_s);
                    d.pc = wv[PC_W-1:0];
                end
                `FBO_OFF_GPR:
                begin
                    wv = fbo_merge({24'h000000, q.gpr}, q.w_d, q.w_s);
                    d.gpr = wv[7:0];
                end
                `FBO_OFF_IO:
                begin
                    wv = fbo_merge({24'h000000, q.io}, q.w_d, q.w_s);
                    d.io = wv[7:0];
                end
                default:
                begin
                    d.b_r = q.b_r == q.b_r ? d.b_r : d.b_r;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.instr <= `FBO_RST_INSTR;
            q.status_register <= `FBO_RST_STATUS_REGISTER;
            q.gpr <= `FBO_RST_GPR;
            q.io <= `FBO_RST_IO;
        end
        else
        begin
            q <= d;
        end
    end

    // Checks
    logic [PC_W-1:0] tgt_pc;
    logic is_br;
    logic t_exp;
    assign tgt_pc = q.pc + PC_W'($signed(x.k)) + PC_W'(1);
    assign is_br = fbo_pkg::fbo_is_branch(x.op);
    assign t_exp = q.gpr[x.bsel];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    branch_target_a: assert property ( // RULE_01
        q.start && is_br && x.taken |=> q.pc == $past(tgt_pc))
        else $error("taken branch target wrong");
    branch_flags_a: assert property ( // RULE_01
        q.start && is_br |=> q.status_register == $past(q.status_register))
        else $error("branch changed flags");
    branch_timing_a: assert property ( // RULE_01
        q.start && is_br && x.taken |=> q.busy ##1 !q.busy)
        else $error("taken branch not two cycles");
    branch_nt_a: assert property ( // RULE_01
        q.start && is_br && !x.taken
        |=> !q.busy && q.pc == $past(q.pc) + PC_W'(1))
        else $error("untaken branch wrong");
    ne_branch_a: assert property ( // RULE_02
        q.start && x.op == fbo_pkg::op_branch_not_equal
        |-> x.taken == !q.status_register[`FBO_STATUS_REGISTER_Z])
        else $error("not-equal condition wrong");
    signed_lt_a: assert property ( // RULE_05
        q.start && x.op == fbo_pkg::op_branch_signed_lt
        |-> x.taken == (q.status_register[`FBO_STATUS_REGISTER_N] ^ q.status_register[`FBO_STATUS_REGISTER_V]))
        else $error("signed lt condition wrong");
    irq_branch_a: assert property ( // RULE_09
        q.start && x.op == fbo_pkg::op_branch_irq_disabled
        |-> x.taken == !q.status_register[`FBO_STATUS_REGISTER_I])
        else $error("irq-disabled condition wrong");
    io_bit_a: assert property ( // RULE_10
        q.start && x.op == fbo_pkg::op_io_bit_set
        |=> q.busy && q.io[$past(x.bsel)] && q.status_register == $past(q.status_register)
        ##1 !q.busy)
        else $error("io bit set wrong");
    rol_carry_a: assert property ( // RULE_11
        q.start && x.op == fbo_pkg::op_rotate_left_carry
        |=> q.status_register[`FBO_STATUS_REGISTER_C] == $past(q.gpr[7]) &&
        q.gpr[0] == $past(q.status_register[`FBO_STATUS_REGISTER_C]))
        else $error("rotate left wrong");
    ror_carry_a: assert property ( // RULE_12
        q.start && x.op == fbo_pkg::op_rotate_right_carry
        |=> q.status_register[`FBO_STATUS_REGISTER_C] == $past(q.gpr[0]) &&
        q.gpr[7] == $past(q.status_register[`FBO_STATUS_REGISTER_C]))
        else $error("rotate right wrong");
    bit_store_a: assert property ( // RULE_13
        q.start && x.op == fbo_pkg::op_bit_to_transfer_flag
        |=> q.status_register[`FBO_STATUS_REGISTER_T] == $past(t_exp) &&
        q.status_register[5:0] == $past(q.status_register[5:0]) && !q.busy)
        else $error("bit store wrong");
    write_resp_a: assert property (
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");

    taken_cov: cover property (q.start && is_br && x.taken);
    io_cov: cover property (q.start && x.op == fbo_pkg::op_io_bit_clear);
    shift_cov: cover property (
        q.start && x.op == fbo_pkg::op_shift_right_arith);
endmodule : fbo_top

// *** dv/flag_branch_and_bit_ops_tb.sv ***
// Self-checking bench for the flag, branch and bit unit over AXI4-Lite
// Assumes fbo_pkg and the map header are compiled first
`timescale 1ns/1ps
`include "fbo_map.svh"

module flag_branch_and_bit_ops_tb;
    logic aclk = 0;
    logic aresetn = 0;
    logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic awr, wrd, bv, arr, rv, busy;
    logic [1:0] br, rr;
    logic [31:0] rd;
    logic [33:0] q[$];
    int failures = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'ha67cbc46;
    logic [31:0] r, r2;
    logic [7:0] es, eg, eio;
    logic [15:0] epc;
    logic [1:0] ec;
    logic et;
    logic [5:0] op;

    fbo_top #(.PC_W(16), .ADDR_W(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rrdy), .busy(busy));

    initial
    begin
        forever #5 aclk = ~aclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Responses are compared in order against the driver's notes
    always @(posedge aclk)
    begin
        if (bv && brdy)
            check({br, 32'h0}, q.size() ? q.pop_front() : 'x);
        if (rv && rrdy)
            check({rr, rd}, q.size() ? q.pop_front() : 'x);
    end

    task automatic wrx(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] resp);
        int n;
        q.push_back({resp, 32'h0});
        @(posedge aclk);
        awa <= a;
        awv <= 1;
        wd <= d;
        wv <= 1;
        brdy <= 1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (awr && awv) awv <= 0;
            if (wrd && wv) wv <= 0;
            if (bv) break;
        end
        brdy <= 0;
        if (n == 40) begin failures++; end_sim(); end
    endtask : wrx

    task automatic rdx(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] resp);
        int n;
        q.push_back({resp, d});
        @(posedge aclk);
        ara <= a;
        arv <= 1;
        rrdy <= 1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (arr && arv) arv <= 0;
            if (rv) break;
        end
        rrdy <= 0;
        if (n == 40) begin failures++; end_sim(); end
    endtask : rdx

    task automatic idle;
        int n;
        for (n = 0; n < 20 && busy !== 1'b0; n++) @(posedge aclk);
        if (n == 20) begin failures++; end_sim(); end
    endtask : idle

    function automatic logic tk(input logic [5:0] o, input logic [7:0] s);
        int ix[16] = '{1, 1, 0, 0, 0, 0, 2, 2, 3, 3, 5, 5, 6, 6, 7, 7};
        int pol[16] = '{1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0};
        logic f;
        f = (o == 9 || o == 10) ? s[2] ^ s[3] : s[ix[o - 1]];
        return f == pol[o - 1][0];
    endfunction : tk

    task automatic model(input logic [5:0] o, input logic [7:0] s, g, io,
        input logic [15:0] pc, input logic [2:0] b, input logic [6:0] k);
        logic c;
        es = s;
        eg = g;
        eio = io;
        epc = pc + 16'h1;
        ec = 2'h1;
        et = 0;
        c = 0;
        if (o >= 1 && o <= 16)
        begin
            et = tk(o, s);
            if (et) {epc, ec} = {pc + {{9{k[6]}}, k} + 16'h1, 2'h2};
        end
        case (o)
            6'd17: {eio[b], ec} = {1'b1, 2'h2};
            6'd18: {eio[b], ec} = {1'b0, 2'h2};
            6'd19: {c, eg} = {g, 1'b0};
            6'd20: {eg, c} = {1'b0, g};
            6'd21: {c, eg} = {g, s[0]};
            6'd22: {eg, c} = {s[0], g};
            6'd23: {eg, c} = {g[7], g};
            6'd24: eg = {g[3:0], g[7:4]};
            6'd25: es[b] = 1'b1;
            6'd26: es[b] = 1'b0;
            6'd27: es[`FBO_STATUS_REGISTER_T] = g[b];
            6'd28: eg[b] = s[`FBO_STATUS_REGISTER_T];
            6'd29: es[`FBO_STATUS_REGISTER_C] = 1'b1;
            6'd30: es[`FBO_STATUS_REGISTER_C] = 1'b0;
            6'd31: es[`FBO_STATUS_REGISTER_N] = 1'b1;
            6'd32: es[`FBO_STATUS_REGISTER_N] = 1'b0;
            default: ;
        endcase
        if (o >= 19 && o <= 23) es[3:0] = {eg[7] ^ c, eg[7], eg == 8'h0, c};
    endtask : model

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        for (int a = 4; a <= 20; a += 4)
            rdx(a[7:0], 32'h0, `FBO_RESP_OKAY);
        rdx(8'h18, 32'h0, `FBO_RESP_SLVERR);
        wrx(8'h1c, 32'h1, `FBO_RESP_SLVERR);
        $display("test reset and map done");
        for (int o = 0; o < 34; o++)
        begin
            for (int i = 0; i < 4; i++)
            begin
                op = (o == 33) ? 6'h3f : o[5:0];
                // Odd passes flip every flag but V, so each branch goes both ways
                if (i % 2 == 0) r = xs();
                else r[7:0] = r[7:0] ^ 8'hf7;
                r2 = xs();
                wrx(`FBO_OFF_STATUS_REGISTER, {24'h0, r[7:0]}, `FBO_RESP_OKAY);
                wrx(`FBO_OFF_PC, {16'h0, r2[15:0]}, `FBO_RESP_OKAY);
                wrx(`FBO_OFF_GPR, {24'h0, r[15:8]}, `FBO_RESP_OKAY);
                wrx(`FBO_OFF_IO, {24'h0, r[23:16]}, `FBO_RESP_OKAY);
                model(op, r[7:0], r[15:8], r[23:16], r2[15:0], r[26:24],
                    r2[22:16]);
                wrx(`FBO_OFF_INSTR, {9'h0, r2[22:16], 5'h0, r[26:24], 2'h0,
                    op}, `FBO_RESP_OKAY);
                idle();
                rdx(`FBO_OFF_STATUS_REGISTER, {24'h0, es}, `FBO_RESP_OKAY);
                rdx(`FBO_OFF_PC, {16'h0, epc}, `FBO_RESP_OKAY);
                rdx(`FBO_OFF_GPR, {24'h0, eg}, `FBO_RESP_OKAY);
                rdx(`FBO_OFF_IO, {24'h0, eio}, `FBO_RESP_OKAY);
                rdx(`FBO_OFF_STAT, {28'h0, ec, et, 1'b0},
                    `FBO_RESP_OKAY);
            end
            $display("test opcode %0d done", op);
        end
        @(posedge aclk);
        @(posedge aclk);
        if (q.size() != 0) failures++;
        end_sim();
    end
endmodule : flag_branch_and_bit_ops_tb
